// file: design/bbc_pkg.sv
// package: register map, field positions and counts of the bit counter
package bbc_pkg;

	// ------------------------------------------------------------
	// register indexes and byte addresses (byte address = 4 * index)
	// ------------------------------------------------------------
	localparam logic [11:0] IDX_COUNT_LOW   = 12'h078;
	localparam logic [11:0] IDX_COUNT_HIGH  = 12'h07A;
	localparam logic [11:0] IDX_ERR_STATUS  = 12'h07C;
	localparam logic [11:0] ADDR_COUNT_LOW  = {IDX_COUNT_LOW[9:0], 2'b00};
	localparam logic [11:0] ADDR_COUNT_HIGH = {IDX_COUNT_HIGH[9:0], 2'b00};
	localparam logic [11:0] ADDR_ERR_STATUS = {IDX_ERR_STATUS[9:0], 2'b00};
	localparam logic [11:0] ADDR_CONTROL    = 12'h200;
	localparam logic [11:0] ADDR_INT_STATUS = 12'h204;
	localparam logic [11:0] ADDR_INT_MASK   = 12'h208;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTL_LOAD_CLEAR = 0;
	localparam int CTL_OVF_IE     = 1;
	localparam int ST_SYNC        = 0;
	localparam int ST_OVERFLOW    = 2;
	localparam int ST_LOCK_LOST   = 4;
	localparam int INT_OVERFLOW   = 0;
	localparam int INT_LOCK_GAIN  = 1;
	localparam int INT_LOCK_LOSS  = 2;

	// ------------------------------------------------------------
	// reset values and counts
	// ------------------------------------------------------------
	localparam logic [31:0] COUNT_RESET   = 32'h0000_0000;
	localparam logic [31:0] COUNT_MAX     = 32'hFFFF_FFFF;
	localparam logic [1:0]  CONTROL_RESET = 2'h0;
	localparam logic [2:0]  INT_RESET     = 3'h0;
	localparam logic [5:0]  LOCK_MATCHES  = 6'h20;
	localparam logic [6:0]  WINDOW_BITS   = 7'h40;
	localparam logic [6:0]  ERR_LIMIT     = 7'h06;

	// lock detector states, gray along search -> locked
	typedef enum logic [1:0] {
		BBC_SEARCH = 2'b00,
		BBC_LOCKED = 2'b01
	} bbc_lock_e;

endpackage

// file: design/bbc_lock_if.sv
// interface: bit stream and lock state between counter and lock detector
`timescale 1ns/1ps
interface bbc_lock_if;
	logic bit_tick;
	logic bit_match;
	logic locked;
	modport det (input bit_tick, input bit_match, output locked);
	modport ctl (output bit_tick, output bit_match, input locked);
endinterface

// file: design/bbc_lock_det.sv
// lock detector: 32 matches to lock, six errors in 64 bits to drop
`timescale 1ns/1ps
module bbc_lock_det (
	input  wire logic pclk,
	input  wire logic presetn,
	bbc_lock_if.det   lk
);

	bbc_pkg::bbc_lock_e state_reg;
	logic [5:0]         run_reg;
	logic [63:0]        hist_reg;
	logic [6:0]         errs_reg;
	logic [6:0]         errs_next;

	// sliding error total: newest error in, oldest out
	always_comb begin
		errs_next = errs_reg + {6'h00, ~lk.bit_match} - {6'h00, hist_reg[63]};
	end

	// ------------------------------------------------------------
	// search and lock
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= bbc_pkg::BBC_SEARCH;
			run_reg   <= 6'h00;
			hist_reg  <= 64'h0000_0000_0000_0000;
			errs_reg  <= 7'h00;
		end else if (lk.bit_tick) begin
			case (state_reg)
				bbc_pkg::BBC_SEARCH: begin
					hist_reg <= 64'h0000_0000_0000_0000;
					errs_reg <= 7'h00;
					if (!lk.bit_match)
						run_reg <= 6'h00;
					else if (run_reg == bbc_pkg::LOCK_MATCHES - 6'h01) begin
						run_reg   <= 6'h00;
						state_reg <= bbc_pkg::BBC_LOCKED; // [R10]
					end else
						run_reg <= run_reg + 6'h01;
				end
				bbc_pkg::BBC_LOCKED: begin
					hist_reg <= {hist_reg[62:0], ~lk.bit_match};
					errs_reg <= errs_next;
					if (errs_next >= bbc_pkg::ERR_LIMIT)
						state_reg <= bbc_pkg::BBC_SEARCH; // [R10]
				end
				default: state_reg <= bbc_pkg::BBC_SEARCH;
			endcase
		end
	end

	assign lk.locked = (state_reg == bbc_pkg::BBC_LOCKED);

endmodule

// file: design/bbc_top.sv
// top: received bit counter of the bit error tester with apb registers
//
// Operation
// [R1] count goes up by one on every received bit clock
// [R2] counting starts once the pattern checker reports lock
// [R3] after starting, loss of lock never halts the count
// [R4] load-clear toggle by software clears the count to zero
// [R5] count holds at all ones and never wraps to zero
// [R6] reaching saturation sets the overflow status flag
// [R7] low and high count words read-only at indexes 78h and 7Ah, reset zero
// [R8] software toggles load-clear at lock and at period end; loss is suspect
// [R9] overflow flag latched, cleared on read; irq needs enable and mask
// [R10] lock after 32 matching bits, lost at six errors in 64
// [R11] a toggle is a software-written zero-to-one of load-clear
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module bbc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_bit_clk,
	input  wire logic        rx_bit_match,
	output logic             bert_irq
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	bbc_lock_if lk ();

	// pin synchronisers and the per-bit tick
	logic        rclk_s1_reg;
	logic        rclk_s2_reg;
	logic        rclk_s3_reg;
	logic        rclk_level_reg;
	logic        match_s1_reg;
	logic        match_s2_reg;
	logic        match_s3_reg;
	logic        tick_reg;
	logic        match_reg;
	logic        rclk_rise;

	// bit counter and its start latch
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic        started_reg;
	logic        counting;
	logic        sat_event;
	logic        lc_event;
	logic        locked_prev_reg;

	// software registers, flags and interrupt
	logic [1:0]  control_reg;
	logic        ovf_flag_reg;
	logic        lost_flag_reg;
	logic [2:0]  int_status_reg;
	logic [2:0]  int_mask_reg;
	logic [2:0]  int_set;
	logic        irq_next;
	logic        ovf_irq;
	logic        gain_irq;
	logic        loss_irq;

	// bus handshake and register strobes
	logic        pready_reg;
	logic [31:0] prdata_reg;
	logic        pslverr_reg;
	logic        access;
	logic        done;
	logic        wr_done;
	logic        rd_done;
	logic [31:0] rd_value;
	logic        rd_mapped;
	logic        ctl_write;
	logic        is_write;
	logic        im_write;
	logic        st_read;

	// one address compare, shared by read mux and write decode
	function automatic logic hit(input logic [11:0] a,
		input logic [11:0] target);
		return a == target;
	endfunction

	// ------------------------------------------------------------
	// received bit clock and match pin synchronisers
	// ------------------------------------------------------------
	// three stages; a change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rclk_s1_reg  <= 1'b0;
			rclk_s2_reg  <= 1'b0;
			rclk_s3_reg  <= 1'b0;
			match_s1_reg <= 1'b0;
			match_s2_reg <= 1'b0;
			match_s3_reg <= 1'b0;
		end else begin
			rclk_s1_reg  <= rx_bit_clk;
			rclk_s2_reg  <= rclk_s1_reg;
			rclk_s3_reg  <= rclk_s2_reg;
			match_s1_reg <= rx_bit_match;
			match_s2_reg <= match_s1_reg;
			match_s3_reg <= match_s2_reg;
		end
	end

	// filtered level of the bit clock, only moves when stages agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rclk_level_reg <= 1'b0;
		else if (rclk_s2_reg == rclk_s3_reg)
			rclk_level_reg <= rclk_s3_reg;
	end

	assign rclk_rise = rclk_s2_reg & rclk_s3_reg & ~rclk_level_reg;

	// one tick per received bit; match moves only when stages agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_reg  <= 1'b0;
			match_reg <= 1'b0;
		end else begin
			tick_reg  <= rclk_rise;
			if (match_s2_reg == match_s3_reg)
				match_reg <= match_s3_reg;
		end
	end

	assign lk.bit_tick  = tick_reg;
	assign lk.bit_match = match_reg;

	// ------------------------------------------------------------
	// lock detector
	// ------------------------------------------------------------
	bbc_lock_det u_lock (
		.pclk    (pclk),
		.presetn (presetn),
		.lk      (lk.det)
	);

	// ------------------------------------------------------------
	// apb handshake
	// ------------------------------------------------------------
	// one wait state gives the read mux a full cycle before prdata
	assign access  = psel & penable;
	assign done    = access & pready_reg;
	assign wr_done = done & pwrite;
	assign rd_done = done & ~pwrite;

	// one decode per register, shared by every owner of that register
	assign ctl_write = wr_done & hit(paddr, bbc_pkg::ADDR_CONTROL);
	assign is_write  = wr_done & hit(paddr, bbc_pkg::ADDR_INT_STATUS);
	assign im_write  = wr_done & hit(paddr, bbc_pkg::ADDR_INT_MASK);
	assign st_read   = rd_done & hit(paddr, bbc_pkg::ADDR_ERR_STATUS);

	// ready rises once per access and falls at the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pready_reg <= 1'b0;
		else
			pready_reg <= access & ~pready_reg;
	end

	// read data stands only while ready does; zero otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_reg <= 32'h0000_0000;
		else if (access && !pready_reg && !pwrite)
			prdata_reg <= rd_value;
		else
			prdata_reg <= 32'h0000_0000;
	end

	// unmapped addresses answer with an error, reads and writes alike
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pslverr_reg <= 1'b0;
		else
			pslverr_reg <= access & ~pready_reg & ~rd_mapped;
	end

	assign pready  = pready_reg;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	// count words are live; software reads low then high word
	always_comb begin
		rd_value  = 32'h0000_0000;
		rd_mapped = 1'b1;
		if (hit(paddr, bbc_pkg::ADDR_COUNT_LOW))
			rd_value = {16'h0000, count_reg[15:0]}; // [R7]
		else if (hit(paddr, bbc_pkg::ADDR_COUNT_HIGH))
			rd_value = {16'h0000, count_reg[31:16]}; // [R7]
		else if (hit(paddr, bbc_pkg::ADDR_ERR_STATUS)) begin
			rd_value[bbc_pkg::ST_SYNC]      = lk.locked;
			rd_value[bbc_pkg::ST_OVERFLOW]  = ovf_flag_reg;
			rd_value[bbc_pkg::ST_LOCK_LOST] = lost_flag_reg;
		end else if (hit(paddr, bbc_pkg::ADDR_CONTROL))
			rd_value = {30'h0000_0000, control_reg};
		else if (hit(paddr, bbc_pkg::ADDR_INT_STATUS))
			rd_value = {29'h0000_0000, int_status_reg};
		else if (hit(paddr, bbc_pkg::ADDR_INT_MASK))
			rd_value = {29'h0000_0000, int_mask_reg};
		else
			rd_mapped = 1'b0;
	end

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	// count words are read-only: writes there are dropped silently
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			control_reg <= bbc_pkg::CONTROL_RESET;
		else if (ctl_write)
			control_reg <= pwdata[1:0];
	end

	// only a written zero-to-one clears; rewriting a one does nothing
	assign lc_event = ctl_write
		&& pwdata[bbc_pkg::CTL_LOAD_CLEAR]
		&& !control_reg[bbc_pkg::CTL_LOAD_CLEAR]; // [R11] [R4]

	// ------------------------------------------------------------
	// bit counter
	// ------------------------------------------------------------
	// start latches on first lock and is never dropped by lock loss
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			started_reg <= 1'b0;
		else if (lk.locked)
			started_reg <= 1'b1; // [R2] [R3]
	end

	assign counting  = started_reg | lk.locked; // [R2] [R3]
	assign sat_event = tick_reg && counting && !lc_event
		&& (count_reg == bbc_pkg::COUNT_MAX - 32'h0000_0001); // [R6]

	// clear wins over a bit arriving in the same cycle
	always_comb begin
		count_next = count_reg;
		if (lc_event)
			count_next = bbc_pkg::COUNT_RESET; // [R4]
		else if (tick_reg && counting
			&& count_reg != bbc_pkg::COUNT_MAX) // [R5]
			count_next = count_reg + 32'h0000_0001; // [R1]
	end

	// plain register; every decision lives in count_next above
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			count_reg <= bbc_pkg::COUNT_RESET; // [R7]
		else
			count_reg <= count_next;
	end

	// ------------------------------------------------------------
	// latched status, cleared on read
	// ------------------------------------------------------------
	// set wins over the read that would clear it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ovf_flag_reg <= 1'b0;
		else if (sat_event)
			ovf_flag_reg <= 1'b1; // [R6] [R9]
		else if (st_read)
			ovf_flag_reg <= 1'b0; // [R9]
	end

	// stays set while searching; a read clears it only once locked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lost_flag_reg <= 1'b0;
		else if (!lk.locked)
			lost_flag_reg <= 1'b1;
		else if (st_read)
			lost_flag_reg <= 1'b0;
	end

	// ------------------------------------------------------------
	// interrupt status, mask and output
	// ------------------------------------------------------------
	// previous lock level, for the gained and lost edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			locked_prev_reg <= 1'b0;
		else
			locked_prev_reg <= lk.locked;
	end

	always_comb begin
		int_set = 3'h0;
		int_set[bbc_pkg::INT_OVERFLOW]  = sat_event;
		int_set[bbc_pkg::INT_LOCK_GAIN] = lk.locked & ~locked_prev_reg;
		int_set[bbc_pkg::INT_LOCK_LOSS] = ~lk.locked & locked_prev_reg;
	end

	// write one to clear; a new event in the same cycle stays set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			int_status_reg <= bbc_pkg::INT_RESET;
		else if (is_write)
			int_status_reg <= (int_status_reg & ~pwdata[2:0]) | int_set;
		else
			int_status_reg <= int_status_reg | int_set;
	end

	// mask has no side effects; it only gates the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			int_mask_reg <= bbc_pkg::INT_RESET;
		else if (im_write)
			int_mask_reg <= pwdata[2:0];
	end

	// overflow needs both its enable and its mask bit
	assign ovf_irq  = int_status_reg[bbc_pkg::INT_OVERFLOW]
		& int_mask_reg[bbc_pkg::INT_OVERFLOW]
		& control_reg[bbc_pkg::CTL_OVF_IE]; // [R9]
	// lock changes only need their mask bit
	assign gain_irq = int_status_reg[bbc_pkg::INT_LOCK_GAIN]
		& int_mask_reg[bbc_pkg::INT_LOCK_GAIN];
	assign loss_irq = int_status_reg[bbc_pkg::INT_LOCK_LOSS]
		& int_mask_reg[bbc_pkg::INT_LOCK_LOSS];
	assign irq_next = ovf_irq | gain_irq | loss_irq;

	// registered so the pin never glitches on the and-or
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bert_irq <= 1'b0;
		else
			bert_irq <= irq_next;
	end

endmodule

// file: verif/bbc_bit_src.sv
// partner model: received pattern bit stream as the framer delivers it
`timescale 1ns/1ps
module bbc_bit_src (
	input  wire logic pclk,
	output logic      bit_clk,
	output logic      bit_match
);
	// --------------------------------------------------------------
	// bit source
	// --------------------------------------------------------------
	initial begin
		bit_clk = 1'b0;
		bit_match = 1'b0;
	end

	// one clock edge per bit, 4 pclk high and 5 pclk low; clock parked low
	// between bursts so no stray bit is seen
	task automatic send(input int n, input logic m);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			bit_match <= m; // held 5 pclk past the rising edge
			repeat (4) @(posedge pclk);
			bit_clk <= 1'b1;
			repeat (4) @(posedge pclk);
			bit_clk <= 1'b0;
		end
		repeat (8) @(posedge pclk); // let the count land
	endtask
endmodule

// file: verif/bbc_top_props.sv
// checker: port-level properties of the received bit counter
`timescale 1ns/1ps
module bbc_top_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rx_bit_clk,
	input wire logic        rx_bit_match,
	input wire logic        bert_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// --------------------------------------------------------------
	// helper shadows of the control and mask registers
	// --------------------------------------------------------------
	logic [2:0] mask_q;
	logic [1:0] ctl_q;
	logic       wr_done;
	logic       mapped;
	assign wr_done = psel && penable && pready && pwrite;
	assign mapped = paddr inside {bbc_pkg::ADDR_COUNT_LOW,
		bbc_pkg::ADDR_COUNT_HIGH, bbc_pkg::ADDR_ERR_STATUS,
		bbc_pkg::ADDR_CONTROL, bbc_pkg::ADDR_INT_STATUS,
		bbc_pkg::ADDR_INT_MASK};

	// shadows follow completed writes only, as the slave does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= 3'h0;
			ctl_q <= 2'h0;
		end else if (wr_done && paddr == bbc_pkg::ADDR_INT_MASK) begin
			mask_q <= pwdata[2:0];
		end else if (wr_done && paddr == bbc_pkg::ADDR_CONTROL) begin
			ctl_q <= pwdata[1:0];
		end
	end

	// --------------------------------------------------------------
	// properties
	// --------------------------------------------------------------
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_read_done;
		psel && penable && pready && !pwrite;
	endsequence

	chk_one_wait: assert property (s_access |=> pready)
		else $error("pready late");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	chk_err_decode: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr wrong for address");
	chk_data_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero when idle");
	chk_count_word: assert property (s_read_done ##0
		(paddr == bbc_pkg::ADDR_COUNT_LOW ||
		paddr == bbc_pkg::ADDR_COUNT_HIGH) |-> prdata[31:16] == 16'h0)
		else $error("count word upper half set");
	chk_ctl_back: assert property (s_read_done ##0
		paddr == bbc_pkg::ADDR_CONTROL |-> prdata == {30'h0, ctl_q})
		else $error("control read back wrong");
	chk_irq_masked: assert property ((mask_q == 3'h0) [*3]
		|-> !bert_irq)
		else $error("irq with all masks off");
endmodule

bind bbc_top bbc_top_props i_bbc_top_props (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rx_bit_clk(rx_bit_clk),
	.rx_bit_match(rx_bit_match), .bert_irq(bert_irq));

// file: verif/bbc_top_tb_top.sv
// testbench: apb master, bit source and scenarios for the counter
`timescale 1ns/1ps
module bbc_top_tb_top;
	localparam logic [11:0] A_LO = bbc_pkg::ADDR_COUNT_LOW;
	localparam logic [11:0] A_HI = bbc_pkg::ADDR_COUNT_HIGH;
	localparam logic [11:0] A_ST = bbc_pkg::ADDR_ERR_STATUS;
	localparam logic [11:0] A_CT = bbc_pkg::ADDR_CONTROL;
	localparam logic [11:0] A_IS = bbc_pkg::ADDR_INT_STATUS;
	localparam logic [11:0] A_IM = bbc_pkg::ADDR_INT_MASK;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        bert_irq, rx_clk, rx_match, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int          n_mismatch, checks, cyc;

	bbc_top i_bbc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_bit_clk(rx_clk),
		.rx_bit_match(rx_match), .bert_irq(bert_irq));
	bbc_bit_src i_src (.pclk(pclk), .bit_clk(rx_clk),
		.bit_match(rx_match));

	// --------------------------------------------------------------
	// clock, timeout and shared tasks
	// --------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// the whole run needs under a thousand cycles; hang guard far above it
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h seen %h", nm, e, s);
		end
	endtask
	// request held until pready is sampled high; data taken there
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait count assumed; only the bench timeout ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, e);
		chk("slverr", {31'h0, err}, 32'h0);
	endtask
	task automatic cnt(input logic [31:0] e);
		rc(A_LO, {16'h0, e[15:0]}, "count low");
		rc(A_HI, {16'h0, e[31:16]}, "count high");
	endtask
	task automatic clr();
		apb(1'b1, A_CT, 32'h0);
		apb(1'b1, A_CT, 32'h1);
	endtask

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_reset();
		cnt(32'h0);
		rc(A_CT, 32'h0, "control");
		rc(A_IS, 32'h0, "int status");
		rc(A_IM, 32'h0, "int mask");
		apb(1'b1, A_LO, 32'h1234);
		cnt(32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
	endtask
	task automatic t_lock();
		i_src.send(10, 1'b1);
		i_src.send(1, 1'b0);
		i_src.send(31, 1'b1);
		cnt(32'h0);
		rc(A_ST, 32'h10, "search status");
		i_src.send(1, 1'b1);
		cnt(32'h0);
		rc(A_ST, 32'h11, "lock status");
		rc(A_ST, 32'h01, "lost flag read");
		i_src.send(5, 1'b1);
		cnt(32'h5);
		rc(A_IS, 32'h2, "gain event");
	endtask
	task automatic t_clear();
		clr();
		cnt(32'h0);
		i_src.send(3, 1'b1);
		apb(1'b1, A_CT, 32'h1);
		cnt(32'h3);
		clr();
		cnt(32'h0);
	endtask
	task automatic t_loss();
		i_src.send(5, 1'b0);
		rc(A_ST, 32'h01, "five errors");
		i_src.send(1, 1'b0);
		rc(A_ST, 32'h10, "six errors");
		i_src.send(4, 1'b1);
		cnt(32'hA);
	endtask
	task automatic t_irq();
		rc(A_IS, 32'h6, "loss event");
		chk("irq masked", {31'h0, bert_irq}, 32'h0);
		apb(1'b1, A_IM, 32'h4);
		repeat (2) @(posedge pclk);
		chk("irq on", {31'h0, bert_irq}, 32'h1);
		apb(1'b1, A_IS, 32'h4);
		repeat (2) @(posedge pclk);
		chk("irq cleared", {31'h0, bert_irq}, 32'h0);
		rc(A_IS, 32'h2, "w1c left");
		// enable bit set with load-clear already one: no clear, no irq
		apb(1'b1, A_CT, 32'h3);
		rc(A_CT, 32'h3, "overflow enable");
		cnt(32'hA);
		repeat (2) @(posedge pclk);
		chk("irq no overflow", {31'h0, bert_irq}, 32'h0);
	endtask

	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		{n_mismatch, checks, cyc} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_lock();
		t_clear();
		t_loss();
		t_irq();
		wrap_up();
	end
endmodule
